// ===== design/pcf_addr_kind.sv
`timescale 1ns/1ns
// Sorts a destination address into broadcast, multicast or unicast.
module pcf_addr_kind (
	input wire logic [47:0] dest_addr, // Destination address, first octet in [47:40].
	output logic is_bcast, // All-ones address.
	output logic is_mcast, // Group address other than broadcast.
	output logic is_ucast // Individual address.
);
	always_comb begin
		is_bcast = (dest_addr == pcf_pkg::PCF_BCAST_ADDR);
		is_mcast = dest_addr[pcf_pkg::PCF_GROUP_BIT] && !is_bcast;
		is_ucast = !dest_addr[pcf_pkg::PCF_GROUP_BIT];
	end
endmodule : pcf_addr_kind

// ===== design/pcf_class_chk.sv
`timescale 1ns/1ns
// Applies one class's enabled checks to a received header.
module pcf_class_chk (
	input wire logic class_en, // Class recognition enabled.
	input wire logic [4:0] chk, // Check enables: mcast, ucast, sa, etype, opcode.
	input wire logic [47:0] dest_addr, // Received destination address.
	input wire logic [47:0] src_addr, // Received source address.
	input wire logic [15:0] ethertype, // Received ethertype.
	input wire logic [15:0] opcode, // Received opcode.
	input wire logic [47:0] pause_source_addr, // Configured source address.
	input wire logic [47:0] pause_multicast_dest_addr, // Configured multicast address.
	input wire logic [47:0] pause_unicast_dest_addr, // Configured unicast address.
	input wire logic [15:0] etype_cfg, // Configured ethertype.
	input wire logic [15:0] opc_min, // Lowest accepted opcode.
	input wire logic [15:0] opc_max, // Highest accepted opcode.
	output logic hit // Header belongs to this class.
);
	logic da_ok;
	logic sa_ok;
	logic et_ok;
	logic op_ok;

	always_comb begin
		// With both address checks on, a match on either one is accepted.
		if (chk[pcf_pkg::PCF_CHK_MCAST] || chk[pcf_pkg::PCF_CHK_UCAST]) begin
			da_ok = (chk[pcf_pkg::PCF_CHK_MCAST] && dest_addr == pause_multicast_dest_addr)
				|| (chk[pcf_pkg::PCF_CHK_UCAST] && dest_addr == pause_unicast_dest_addr);
		end else begin
			da_ok = 1'b1;
		end
		sa_ok = !chk[pcf_pkg::PCF_CHK_SA] || (src_addr == pause_source_addr);
		et_ok = !chk[pcf_pkg::PCF_CHK_ETYPE] || (ethertype == etype_cfg);
		op_ok = !chk[pcf_pkg::PCF_CHK_OPCODE] || pcf_pkg::in_range(opcode, opc_min, opc_max);
		hit = class_en && da_ok && sa_ok && et_ok && op_ok;
	end
endmodule : pcf_class_chk

// ===== design/pcf_classifier.sv
`timescale 1ns/1ns
module pcf_classifier (
	input wire logic core_clk, // Receive clock, 250 MHz.
	input wire logic rstn, // Asynchronous reset, active low.
	input wire logic psel, // APB select.
	input wire logic penable, // APB enable.
	input wire logic pwrite, // APB write.
	input wire logic [7:0] paddr, // APB byte address.
	input wire logic [31:0] pwdata, // APB write data.
	input wire logic [3:0] pstrb, // APB byte strobes.
	output logic [31:0] prdata, // APB read data.
	output logic pready, // APB ready.
	output logic pslverr, // APB error on unmapped address.
	input wire logic rx_hdr_valid, // One-cycle strobe: header fields below valid.
	input wire logic rx_fcs_good, // Frame was received good.
	input wire logic [47:0] rx_dest_addr, // Destination address.
	input wire logic [47:0] rx_src_addr, // Source address.
	input wire logic [15:0] rx_ethertype, // Ethertype.
	input wire logic [15:0] rx_opcode, // Control opcode.
	output logic [3:0] class_hit, // Pulse per class, bit order of pcf_class_t.
	output logic stat_unicast, // Pulse per good unicast frame.
	output logic stat_multicast, // Pulse per good multicast frame.
	output logic stat_broadcast // Pulse per good broadcast frame.
);
	logic [3:0] class_en;
	logic [31:0] chk_word;
	logic [47:0] pause_source_addr;
	logic [47:0] pause_multicast_dest_addr;
	logic [47:0] pause_unicast_dest_addr;
	logic [31:0] etype_ctrl;
	logic [31:0] etype_pause;
	logic [31:0] opc_gcp;
	logic [31:0] opc_pcp;
	logic [31:0] opc_pause;
	logic [3:0] last_hits;
	logic [15:0] good_count;
	logic [3:0] next_class_en;
	logic [31:0] next_chk_word;
	logic [47:0] next_pause_source_addr;
	logic [47:0] next_pause_multicast_dest_addr;
	logic [47:0] next_pause_unicast_dest_addr;
	logic [31:0] next_etype_ctrl;
	logic [31:0] next_etype_pause;
	logic [31:0] next_opc_gcp;
	logic [31:0] next_opc_pcp;
	logic [31:0] next_opc_pause;
	logic [31:0] next_prdata;
	logic wr_acc;
	logic rd_setup;
	logic mapped;
	logic [31:0] rd_word;
	logic [31:0] tmp;

	assign pready = 1'b1;
	assign wr_acc = psel && penable && pwrite;
	assign rd_setup = psel && !penable && !pwrite;

	always_comb begin
		mapped = 1'b1;
		if (paddr == pcf_pkg::PCF_OFF_ENABLE) begin
			rd_word = {28'h0000000, class_en};
		end else if (paddr == pcf_pkg::PCF_OFF_CHECKS) begin
			rd_word = chk_word;
		end else if (paddr == pcf_pkg::PCF_OFF_SA_LO) begin
			rd_word = pause_source_addr[31:0];
		end else if (paddr == pcf_pkg::PCF_OFF_SA_HI) begin
			rd_word = {16'h0000, pause_source_addr[47:32]};
		end else if (paddr == pcf_pkg::PCF_OFF_MC_LO) begin
			rd_word = pause_multicast_dest_addr[31:0];
		end else if (paddr == pcf_pkg::PCF_OFF_MC_HI) begin
			rd_word = {16'h0000, pause_multicast_dest_addr[47:32]};
		end else if (paddr == pcf_pkg::PCF_OFF_UC_LO) begin
			rd_word = pause_unicast_dest_addr[31:0];
		end else if (paddr == pcf_pkg::PCF_OFF_UC_HI) begin
			rd_word = {16'h0000, pause_unicast_dest_addr[47:32]};
		end else if (paddr == pcf_pkg::PCF_OFF_ETYPE_CTRL) begin
			rd_word = etype_ctrl;
		end else if (paddr == pcf_pkg::PCF_OFF_ETYPE_PAUSE) begin
			rd_word = etype_pause;
		end else if (paddr == pcf_pkg::PCF_OFF_OPC_GCP) begin
			rd_word = opc_gcp;
		end else if (paddr == pcf_pkg::PCF_OFF_OPC_PCP) begin
			rd_word = opc_pcp;
		end else if (paddr == pcf_pkg::PCF_OFF_OPC_PAUSE) begin
			rd_word = opc_pause;
		end else if (paddr == pcf_pkg::PCF_OFF_STATUS) begin
			rd_word = {good_count, 12'h000, last_hits};
		end else begin
			rd_word = 32'h0000_0000;
			mapped = 1'b0;
		end
		pslverr = psel && penable && !mapped;
	end

	always_comb begin
		next_class_en = class_en;
		next_chk_word = chk_word;
		next_pause_source_addr = pause_source_addr;
		next_pause_multicast_dest_addr = pause_multicast_dest_addr;
		next_pause_unicast_dest_addr = pause_unicast_dest_addr;
		next_etype_ctrl = etype_ctrl;
		next_etype_pause = etype_pause;
		next_opc_gcp = opc_gcp;
		next_opc_pcp = opc_pcp;
		next_opc_pause = opc_pause;
		next_prdata = rd_setup ? rd_word : prdata;
		tmp = 32'h0000_0000;
		if (wr_acc) begin
			if (paddr == pcf_pkg::PCF_OFF_ENABLE) begin
				tmp = pcf_pkg::merge({28'h0000000, class_en}, pwdata, pstrb);
				next_class_en = tmp[3:0];
			end else if (paddr == pcf_pkg::PCF_OFF_CHECKS) begin
				next_chk_word = pcf_pkg::merge(chk_word, pwdata, pstrb);
			end else if (paddr == pcf_pkg::PCF_OFF_SA_LO) begin
				next_pause_source_addr[31:0] =
					pcf_pkg::merge(pause_source_addr[31:0], pwdata, pstrb);
			end else if (paddr == pcf_pkg::PCF_OFF_SA_HI) begin
				tmp = pcf_pkg::merge({16'h0000, pause_source_addr[47:32]}, pwdata, pstrb);
				next_pause_source_addr[47:32] = tmp[15:0];
			end else if (paddr == pcf_pkg::PCF_OFF_MC_LO) begin
				next_pause_multicast_dest_addr[31:0] =
					pcf_pkg::merge(pause_multicast_dest_addr[31:0], pwdata, pstrb);
			end else if (paddr == pcf_pkg::PCF_OFF_MC_HI) begin
				tmp = pcf_pkg::merge({16'h0000, pause_multicast_dest_addr[47:32]}, pwdata,
					pstrb);
				next_pause_multicast_dest_addr[47:32] = tmp[15:0];
			end else if (paddr == pcf_pkg::PCF_OFF_UC_LO) begin
				next_pause_unicast_dest_addr[31:0] =
					pcf_pkg::merge(pause_unicast_dest_addr[31:0], pwdata, pstrb);
			end else if (paddr == pcf_pkg::PCF_OFF_UC_HI) begin
				tmp = pcf_pkg::merge({16'h0000, pause_unicast_dest_addr[47:32]}, pwdata,
					pstrb);
				next_pause_unicast_dest_addr[47:32] = tmp[15:0];
			end else if (paddr == pcf_pkg::PCF_OFF_ETYPE_CTRL) begin
				next_etype_ctrl = pcf_pkg::merge(etype_ctrl, pwdata, pstrb);
			end else if (paddr == pcf_pkg::PCF_OFF_ETYPE_PAUSE) begin
				next_etype_pause = pcf_pkg::merge(etype_pause, pwdata, pstrb);
			end else if (paddr == pcf_pkg::PCF_OFF_OPC_GCP) begin
				next_opc_gcp = pcf_pkg::merge(opc_gcp, pwdata, pstrb);
			end else if (paddr == pcf_pkg::PCF_OFF_OPC_PCP) begin
				next_opc_pcp = pcf_pkg::merge(opc_pcp, pwdata, pstrb);
			end else if (paddr == pcf_pkg::PCF_OFF_OPC_PAUSE) begin
				next_opc_pause = pcf_pkg::merge(opc_pause, pwdata, pstrb);
			end
		end
	end

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			class_en <= pcf_pkg::PCF_RST_ENABLE;
			chk_word <= pcf_pkg::PCF_RST_WORD;
			pause_source_addr <= {16'h0000, pcf_pkg::PCF_RST_WORD};
			pause_multicast_dest_addr <= {16'h0000, pcf_pkg::PCF_RST_WORD};
			pause_unicast_dest_addr <= {16'h0000, pcf_pkg::PCF_RST_WORD};
			etype_ctrl <= pcf_pkg::PCF_RST_WORD;
			etype_pause <= pcf_pkg::PCF_RST_WORD;
			opc_gcp <= pcf_pkg::PCF_RST_WORD;
			opc_pcp <= pcf_pkg::PCF_RST_WORD;
			opc_pause <= pcf_pkg::PCF_RST_WORD;
			prdata <= pcf_pkg::PCF_RST_WORD;
		end else begin
			class_en <= next_class_en;
			chk_word <= next_chk_word;
			pause_source_addr <= next_pause_source_addr;
			pause_multicast_dest_addr <= next_pause_multicast_dest_addr;
			pause_unicast_dest_addr <= next_pause_unicast_dest_addr;
			etype_ctrl <= next_etype_ctrl;
			etype_pause <= next_etype_pause;
			opc_gcp <= next_opc_gcp;
			opc_pcp <= next_opc_pcp;
			opc_pause <= next_opc_pause;
			prdata <= next_prdata;
		end
	end

	// Per-class configured ethertype and opcode window.
	logic [15:0] cfg_etype [pcf_pkg::PCF_NCLASS];
	logic [15:0] cfg_min [pcf_pkg::PCF_NCLASS];
	logic [15:0] cfg_max [pcf_pkg::PCF_NCLASS];
	logic [3:0] hit_now;

	always_comb begin
		cfg_etype[pcf_pkg::PCF_GCP] = etype_ctrl[pcf_pkg::PCF_LO16 +: 16];
		cfg_min[pcf_pkg::PCF_GCP] = opc_gcp[pcf_pkg::PCF_LO16 +: 16];
		cfg_max[pcf_pkg::PCF_GCP] = opc_gcp[pcf_pkg::PCF_HI16 +: 16];
		cfg_etype[pcf_pkg::PCF_PCP] = etype_ctrl[pcf_pkg::PCF_HI16 +: 16];
		cfg_min[pcf_pkg::PCF_PCP] = opc_pcp[pcf_pkg::PCF_LO16 +: 16];
		cfg_max[pcf_pkg::PCF_PCP] = opc_pcp[pcf_pkg::PCF_HI16 +: 16];
		cfg_etype[pcf_pkg::PCF_GPP] = etype_pause[pcf_pkg::PCF_LO16 +: 16];
		cfg_min[pcf_pkg::PCF_GPP] = opc_pause[pcf_pkg::PCF_LO16 +: 16];
		cfg_max[pcf_pkg::PCF_GPP] = opc_pause[pcf_pkg::PCF_LO16 +: 16];
		cfg_etype[pcf_pkg::PCF_PPP] = etype_pause[pcf_pkg::PCF_HI16 +: 16];
		cfg_min[pcf_pkg::PCF_PPP] = opc_pause[pcf_pkg::PCF_HI16 +: 16];
		cfg_max[pcf_pkg::PCF_PPP] = opc_pause[pcf_pkg::PCF_HI16 +: 16];
	end

	// Each class is gated by its enable and its own check bits.
	for (genvar c = 0; c < pcf_pkg::PCF_NCLASS; c++) begin : g_class
		pcf_class_chk u_chk (
			.class_en(class_en[c]),
			.chk(chk_word[c*pcf_pkg::PCF_CHK_STRIDE +: pcf_pkg::PCF_CHK_WIDTH]),
			.dest_addr(rx_dest_addr),
			.src_addr(rx_src_addr),
			.ethertype(rx_ethertype),
			.opcode(rx_opcode),
			.pause_source_addr(pause_source_addr),
			.pause_multicast_dest_addr(pause_multicast_dest_addr),
			.pause_unicast_dest_addr(pause_unicast_dest_addr),
			.etype_cfg(cfg_etype[c]),
			.opc_min(cfg_min[c]),
			.opc_max(cfg_max[c]),
			.hit(hit_now[c])
		);
	end

	logic kind_bcast;
	logic kind_mcast;
	logic kind_ucast;

	pcf_addr_kind u_kind (
		.dest_addr(rx_dest_addr),
		.is_bcast(kind_bcast),
		.is_mcast(kind_mcast),
		.is_ucast(kind_ucast)
	);

	logic good;
	logic [3:0] next_class_hit;
	logic next_stat_unicast;
	logic next_stat_multicast;
	logic next_stat_broadcast;
	logic [3:0] next_last_hits;
	logic [15:0] next_good_count;

	always_comb begin
		good = rx_hdr_valid && rx_fcs_good;
		next_class_hit = good ? hit_now : 4'h0;
		next_stat_unicast = good && kind_ucast;
		next_stat_multicast = good && kind_mcast;
		next_stat_broadcast = good && kind_bcast;
		next_last_hits = good ? hit_now : last_hits;
		next_good_count = good ? good_count + 16'h0001 : good_count;
	end

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			class_hit <= 4'h0;
			stat_unicast <= 1'b0;
			stat_multicast <= 1'b0;
			stat_broadcast <= 1'b0;
			last_hits <= 4'h0;
			good_count <= 16'h0000;
		end else begin
			class_hit <= next_class_hit;
			stat_unicast <= next_stat_unicast;
			stat_multicast <= next_stat_multicast;
			stat_broadcast <= next_stat_broadcast;
			last_hits <= next_last_hits;
			good_count <= next_good_count;
		end
	end

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rstn);

	sequence s_good;
		rx_hdr_valid && rx_fcs_good;
	endsequence

	function automatic logic chk_on(input logic [31:0] w, input int c, input int b);
		return w[c*pcf_pkg::PCF_CHK_STRIDE + b];
	endfunction : chk_on

	property p_gcp_off;
		s_good and !class_en[pcf_pkg::PCF_GCP] |=> !class_hit[pcf_pkg::PCF_GCP];
	endproperty
	a_gcp_off: assert property (p_gcp_off) else $error("global control hit while disabled");

	property p_pcp_off;
		rx_hdr_valid && !class_en[pcf_pkg::PCF_PCP] |=> !class_hit[pcf_pkg::PCF_PCP];
	endproperty
	a_pcp_off: assert property (p_pcp_off) else $error("priority control hit while off");

	property p_gpp_sa;
		rx_hdr_valid && chk_on(chk_word, 2, pcf_pkg::PCF_CHK_SA)
			&& rx_src_addr != pause_source_addr |=> !class_hit[pcf_pkg::PCF_GPP];
	endproperty
	a_gpp_sa: assert property (p_gpp_sa) else $error("global pause hit with wrong source");

	property p_gcp_etype;
		rx_hdr_valid && chk_on(chk_word, 0, pcf_pkg::PCF_CHK_ETYPE)
			&& rx_ethertype != etype_ctrl[15:0] |=> !class_hit[pcf_pkg::PCF_GCP];
	endproperty
	a_gcp_etype: assert property (p_gcp_etype) else $error("gcp hit with wrong ethertype");

	property p_gpp_opcode;
		rx_hdr_valid && chk_on(chk_word, 2, pcf_pkg::PCF_CHK_OPCODE)
			&& rx_opcode != opc_pause[15:0] |=> !class_hit[pcf_pkg::PCF_GPP];
	endproperty
	a_gpp_opcode: assert property (p_gpp_opcode) else $error("gpp hit, opcode differs");

	property p_pcp_range;
		rx_hdr_valid && chk_on(chk_word, 1, pcf_pkg::PCF_CHK_OPCODE)
			&& (rx_opcode > opc_pcp[31:16] || rx_opcode < opc_pcp[15:0])
			|=> !class_hit[pcf_pkg::PCF_PCP];
	endproperty
	a_pcp_range: assert property (p_pcp_range) else $error("pcp hit, opcode out of range");

	property p_ppp_free_pass;
		s_good and class_en[pcf_pkg::PCF_PPP] && chk_word[31:24] == 8'h00
			|=> class_hit[pcf_pkg::PCF_PPP];
	endproperty
	a_ppp_free_pass: assert property (p_ppp_free_pass) else $error("ppp missed unchecked frame");

	property p_gcp_min_edge;
		s_good and class_en[pcf_pkg::PCF_GCP] && chk_word[7:0] == 8'h10
			&& rx_opcode == opc_gcp[15:0] && opc_gcp[15:0] <= opc_gcp[31:16]
			|=> class_hit[pcf_pkg::PCF_GCP];
	endproperty
	a_gcp_min_edge: assert property (p_gcp_min_edge) else $error("gcp lower bound refused");

	property p_bcast_stat;
		s_good and rx_dest_addr == pcf_pkg::PCF_BCAST_ADDR
			|=> stat_broadcast && !stat_multicast && !stat_unicast;
	endproperty
	a_bcast_stat: assert property (p_bcast_stat) else $error("broadcast statistic missing");

	property p_stat_cause;
		stat_unicast || stat_multicast || stat_broadcast |-> $past(rx_hdr_valid && rx_fcs_good);
	endproperty
	a_stat_cause: assert property (p_stat_cause) else $error("statistic without good frame");

endmodule : pcf_classifier

// ===== design/pcf_pkg.sv
package pcf_pkg;

	// Frame classes, also the bit order of the enable field and hit outputs.
	typedef enum logic [1:0] {
		PCF_GCP = 2'b00,
		PCF_PCP = 2'b01,
		PCF_GPP = 2'b10,
		PCF_PPP = 2'b11
	} pcf_class_t;

	localparam int PCF_NCLASS = 4;

	// Register byte offsets.
	localparam logic [7:0] PCF_OFF_ENABLE = 8'h00;
	localparam logic [7:0] PCF_OFF_CHECKS = 8'h04;
	localparam logic [7:0] PCF_OFF_SA_LO = 8'h08;
	localparam logic [7:0] PCF_OFF_SA_HI = 8'h0c;
	localparam logic [7:0] PCF_OFF_MC_LO = 8'h10;
	localparam logic [7:0] PCF_OFF_MC_HI = 8'h14;
	localparam logic [7:0] PCF_OFF_UC_LO = 8'h18;
	localparam logic [7:0] PCF_OFF_UC_HI = 8'h1c;
	localparam logic [7:0] PCF_OFF_ETYPE_CTRL = 8'h20;
	localparam logic [7:0] PCF_OFF_ETYPE_PAUSE = 8'h24;
	localparam logic [7:0] PCF_OFF_OPC_GCP = 8'h28;
	localparam logic [7:0] PCF_OFF_OPC_PCP = 8'h2c;
	localparam logic [7:0] PCF_OFF_OPC_PAUSE = 8'h30;
	localparam logic [7:0] PCF_OFF_STATUS = 8'h34;

	// Per-class check bits inside CHECKS; class c uses bits c*8 upward.
	localparam int PCF_CHK_STRIDE = 8;
	localparam int PCF_CHK_MCAST = 0;
	localparam int PCF_CHK_UCAST = 1;
	localparam int PCF_CHK_SA = 2;
	localparam int PCF_CHK_ETYPE = 3;
	localparam int PCF_CHK_OPCODE = 4;
	localparam int PCF_CHK_WIDTH = 5;

	// Field positions of 32-bit words carrying two 16-bit values.
	localparam int PCF_LO16 = 0;
	localparam int PCF_HI16 = 16;
	// Status fields: last good frame's class hits and count of good frames.
	localparam int PCF_ST_HITS = 0;
	localparam int PCF_ST_COUNT = 16;

	localparam logic [31:0] PCF_RST_WORD = 32'h0000_0000;
	localparam logic [3:0] PCF_RST_ENABLE = 4'h0;
	localparam logic [47:0] PCF_BCAST_ADDR = 48'hffff_ffff_ffff;
	localparam int PCF_GROUP_BIT = 40;

	// Byte-lane merge of an APB write into a stored word.
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
		input logic [3:0] strb);
		logic [31:0] res;
		res = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				res[i*8 +: 8] = wd[i*8 +: 8];
			end
		end
		return res;
	endfunction : merge

	function automatic logic in_range(input logic [15:0] v, input logic [15:0] lo,
		input logic [15:0] hi);
		return (v >= lo) && (v <= hi);
	endfunction : in_range

endpackage : pcf_pkg

// ===== verif/pcf_classifier_tb.sv
`timescale 1ns/1ns
module pcf_classifier_tb;
	logic core_clk = 1'b0;
	logic rstn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [3:0] pstrb = 4'hf;
	logic [31:0] prdata, rd_v, a, b, v;
	logic pready, pslverr, er_v, rx_hdr_valid, rx_fcs_good;
	logic stat_unicast, stat_multicast, stat_broadcast;
	logic [47:0] rx_dest_addr, rx_src_addr, da, sa;
	logic [15:0] rx_ethertype, rx_opcode, et, op;
	logic [3:0] class_hit;
	logic [3:0] last_h = 4'h0;
	logic [15:0] good_n = 16'h0;
	logic [6:0] eo = 7'h0;
	logic [31:0] cfg [0:13];
	logic [31:0] seed = 32'h336b;
	int fails = 0;
	int cmp_count = 0;
	int cyc = 0;

	always #2 core_clk = ~core_clk;

	pcf_classifier pcf_classifier_i (.core_clk(core_clk), .rstn(rstn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .rx_hdr_valid(rx_hdr_valid),
		.rx_fcs_good(rx_fcs_good), .rx_dest_addr(rx_dest_addr), .rx_src_addr(rx_src_addr),
		.rx_ethertype(rx_ethertype), .rx_opcode(rx_opcode), .class_hit(class_hit),
		.stat_unicast(stat_unicast), .stat_multicast(stat_multicast),
		.stat_broadcast(stat_broadcast));

	pcf_rx_src pcf_rx_src_i (.core_clk(core_clk), .rx_hdr_valid(rx_hdr_valid),
		.rx_fcs_good(rx_fcs_good), .rx_dest_addr(rx_dest_addr), .rx_src_addr(rx_src_addr),
		.rx_ethertype(rx_ethertype), .rx_opcode(rx_opcode));

	function automatic logic [31:0] nxt(input logic [31:0] x);
		for (int k = 0; k < 8; k++) begin
			x = (x >> 1) ^ ({32{x[0]}} & 32'h80200003);
		end
		return x;
	endfunction : nxt

	function automatic logic [31:0] mk(input int i);
		case (i)
			0: return 32'h0000000f;
			1: return 32'h1f1f1f1f;
			3, 5, 7: return 32'h0000ffff;
			default: return 32'hffffffff;
		endcase
	endfunction : mk

	// Reference classifier: a class hits when enabled and every enabled check passes, a match on either address check sufficing when both are enabled.
	function automatic logic [3:0] mdl(input logic [47:0] d, input logic [47:0] s,
		input logic [15:0] e, input logic [15:0] o);
		logic [3:0] h;
		logic [4:0] k;
		logic dm, om;
		for (int c = 0; c < 4; c++) begin
			k = cfg[1][c*8 +: 5];
			dm = (k[0] && d == {cfg[5][15:0], cfg[4]}) || (k[1] && d == {cfg[7][15:0], cfg[6]});
			if (c < 2) begin
				om = o >= cfg[10 + c][15:0] && o <= cfg[10 + c][31:16];
			end else begin
				om = o == cfg[12][(c - 2)*16 +: 16];
			end
			h[c] = cfg[0][c] && (dm || !(k[0] || k[1])) && (!k[2] || s == {cfg[3][15:0], cfg[2]})
				&& (!k[3] || e == cfg[8 + c/2][(c%2)*16 +: 16]) && (!k[4] || om);
		end
		return h;
	endfunction : mdl

	task ck(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			fails++;
			$display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask : ck

	task test_done();
		$display("comparisons %0d mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : test_done

	task rnd(output logic [31:0] r);
		seed = nxt(seed);
		r = seed;
	endtask : rnd

	// Entered just after an edge; leaves psel high so a following setup may come at once.
	task apb(input logic w, input logic [7:0] ad, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= ad;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		do begin
			@(posedge core_clk);
		end while (pready !== 1'b1);
		rd_v = prdata;
		er_v = pslverr;
		penable <= 1'b0;
	endtask : apb

	always @(posedge core_clk) begin
		cyc++;
		if (cyc == 30000) begin
			fails++;
			test_done();
		end
	end

	always @(posedge core_clk) begin
		if (rstn !== 1'b1) begin
			eo = 7'h0;
		end else begin
			ck(32'(class_hit[0]), 32'(eo[0]));
			ck(32'(class_hit[1]), 32'(eo[1]));
			ck(32'(class_hit[2]), 32'(eo[2]));
			ck(32'(class_hit[3]), 32'(eo[3]));
			ck(32'({stat_broadcast, stat_multicast, stat_unicast}), 32'(eo[6:4]));
			eo = 7'h0;
			if (rx_hdr_valid === 1'b1 && rx_fcs_good === 1'b1) begin
				eo[3:0] = mdl(rx_dest_addr, rx_src_addr, rx_ethertype, rx_opcode);
				eo[6] = rx_dest_addr == pcf_pkg::PCF_BCAST_ADDR;
				eo[5] = rx_dest_addr[40] && !eo[6];
				eo[4] = !rx_dest_addr[40];
				last_h = eo[3:0];
				good_n++;
			end
		end
	end

	initial begin
		cfg[13] = 32'h0;
		repeat (16) @(posedge core_clk);
		rstn <= 1'b1;
		@(posedge core_clk);
		for (int i = 0; i < 14; i++) begin
			apb(1'b0, 8'(i*4), 32'h0);
			ck(rd_v, pcf_pkg::PCF_RST_WORD);
		end
		apb(1'b0, 8'h38, 32'h0);
		ck(rd_v, 32'h0);
		ck(32'(er_v), 32'h1);
		apb(1'b1, 8'h38, 32'hffffffff);
		ck(32'(er_v), 32'h1);
		// Byte strobes: only lanes 0 and 2 of this write may land.
		pstrb <= 4'h5;
		apb(1'b1, pcf_pkg::PCF_OFF_ETYPE_CTRL, 32'hffffffff);
		pstrb <= 4'hf;
		apb(1'b0, pcf_pkg::PCF_OFF_ETYPE_CTRL, 32'h0);
		ck(rd_v, 32'h00ff00ff);
		for (int r = 0; r < 40; r++) begin
			for (int i = 0; i < 13; i++) begin
				rnd(v);
				if (i == 10 || i == 11) begin
					v = {16'({8'h00, v[7:0]} + v[19:16]), 8'h00, v[7:0]};
				end else if (i == 1 && r % 4 == 0) begin
					v = {8'h00, v[23:8], 8'h10};
				end
				cfg[i] = v;
				apb(1'b1, 8'(i*4), v);
				apb(1'b0, 8'(i*4), 32'h0);
				ck(rd_v & (i == 1 ? 32'h1f1f1f1f : 32'hffffffff), v & mk(i));
			end
			psel <= 1'b0;
			@(posedge core_clk);
			for (int f = 0; f < 40; f++) begin
				rnd(a);
				rnd(b);
				case (a[1:0])
					2'd0: da = {cfg[5][15:0], cfg[4]};
					2'd1: da = {cfg[7][15:0], cfg[6]};
					2'd2: da = pcf_pkg::PCF_BCAST_ADDR;
					default: da = {a[31:16], b};
				endcase
				sa = a[2] ? {cfg[3][15:0], cfg[2]} : {b, a[31:16]};
				et = a[5] ? b[15:0] : cfg[8 + a[4]][a[3]*16 +: 16];
				op = a[8] ? (a[9] ? cfg[10][31:16] + 16'h1 : b[31:16]) :
					cfg[10 + a[7:6]][a[9]*16 +: 16];
				pcf_rx_src_i.send(da, sa, et, op, a[12:10] != 3'h0);
				if (a[13]) begin
					pcf_rx_src_i.idle();
				end
			end
			pcf_rx_src_i.idle();
			@(posedge core_clk);
		end
		apb(1'b0, pcf_pkg::PCF_OFF_STATUS, 32'h0);
		ck(32'(rd_v[3:0]), 32'(last_h));
		ck(32'(rd_v[31:16]), 32'(good_n));
		test_done();
	end
endmodule : pcf_classifier_tb

// ===== verif/pcf_rx_src.sv
`timescale 1ns/1ns
// Receive-side header source; each idle cycle drops the strobe and toggles every other field, so stale data never matches.
module pcf_rx_src (
	input wire logic core_clk, // Receive clock.
	output logic rx_hdr_valid, // Header strobe.
	output logic rx_fcs_good, // Frame good.
	output logic [47:0] rx_dest_addr, // Destination address.
	output logic [47:0] rx_src_addr, // Source address.
	output logic [15:0] rx_ethertype, // Ethertype.
	output logic [15:0] rx_opcode // Opcode.
);
	initial begin
		{rx_hdr_valid, rx_fcs_good, rx_dest_addr, rx_src_addr, rx_ethertype, rx_opcode} = 130'h0;
	end

	task send(input logic [47:0] da, input logic [47:0] sa, input logic [15:0] et,
		input logic [15:0] op, input logic good);
		rx_hdr_valid <= 1'b1;
		rx_fcs_good <= good;
		rx_dest_addr <= da;
		rx_src_addr <= sa;
		rx_ethertype <= et;
		rx_opcode <= op;
		@(posedge core_clk);
	endtask : send

	task idle();
		rx_hdr_valid <= 1'b0;
		{rx_fcs_good, rx_dest_addr, rx_src_addr, rx_ethertype, rx_opcode} <=
			~{rx_fcs_good, rx_dest_addr, rx_src_addr, rx_ethertype, rx_opcode};
		@(posedge core_clk);
	endtask : idle
endmodule : pcf_rx_src
